// file: rtl/ep0c_pkg.sv
package ep0c_pkg;
  // command addresses
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h2e;
  localparam logic [7:0] ADDR_DESCRIPTOR_LOAD_PORT_LOAD = 8'h30;
  localparam logic [7:0] ADDR_EP0_BUF = 8'h31;
  localparam logic [7:0] ADDR_SETUP = 8'h32;
  localparam logic [7:0] ADDR_EP0_COUNT = 8'h33;
  // sizes
  localparam int DESCRIPTOR_LOAD_PORT_BYTES = 500;
  localparam int BUF_BYTES = 64;
  localparam int SETUP_BYTES = 8;
  // interrupt enable mask layout and reset value
  localparam logic [7:0] INT_ENABLE_RESET = 8'hff;
  localparam int INT_SETUP_BIT = 7;
  localparam int INT_BUF_BIT = 6;
  // one command transfer from the external master
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ep0c_cmd_t;
  // descriptor loader phases
  typedef enum logic [1:0] {
    DESCRIPTOR_LOAD_PORT_LEN_LO,
    DESCRIPTOR_LOAD_PORT_LEN_HI,
    DESCRIPTOR_LOAD_PORT_DATA
  } ep0c_descriptor_load_port_state_t;
endpackage

// file: rtl/ep0c_nibble_pack.sv
`timescale 1ns/1ps
// joins two nibble transfers into one byte, low nibble first
module ep0c_nibble_pack
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic nib_we,
  input wire logic [3:0] nib,
  output logic byte_we,
  output logic [7:0] byte_out
);
  logic have_low; // low nibble already held
  logic [3:0] low_nib; // held low nibble

  // nibble phase and byte assembly
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      have_low <= 1'b0;
      low_nib <= 4'h0;
      byte_we <= 1'b0;
      byte_out <= 8'h00;
    end
    else
    begin
      byte_we <= 1'b0;
      if (nib_we)
      begin
        if (have_low)
        begin
          // second nibble completes the byte
          byte_out <= {nib, low_nib};
          byte_we <= 1'b1;
          have_low <= 1'b0;
        end
        else
        begin
          low_nib <= nib;
          have_low <= 1'b1;
        end
      end
    end
  end
endmodule

// file: rtl/ep0c_top.sv
`timescale 1ns/1ps
module ep0c_top
(
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire ep0c_pkg::ep0c_cmd_t CMD,
  output logic [7:0] CMD_RDATA,
  output logic CMD_RVALID,
  output logic INT_N,
  output logic EP0_STALL,
  input wire logic USB_SETUP_WE,
  input wire logic [2:0] USB_SETUP_IDX,
  input wire logic [7:0] USB_SETUP_DATA,
  input wire logic USB_SETUP_DONE,
  input wire logic USB_OUT_WE,
  input wire logic [7:0] USB_OUT_DATA,
  input wire logic USB_OUT_DONE,
  output logic USB_IN_GO,
  output logic [6:0] USB_IN_COUNT,
  input wire logic [5:0] USB_IN_RADDR,
  output logic [7:0] USB_IN_RDATA,
  input wire logic USB_IN_DONE,
  input wire logic [8:0] USB_DESCRIPTOR_LOAD_PORT_RADDR,
  output logic [7:0] USB_DESCRIPTOR_LOAD_PORT_RDATA,
  output logic [15:0] DESCRIPTOR_LOAD_PORT_LEN,
  output logic DESCRIPTOR_LOAD_PORT_READY
);
  localparam logic [6:0] BUF_MAX = 7'(ep0c_pkg::BUF_BYTES);
  localparam logic [15:0] DESCRIPTOR_LOAD_PORT_MAX = 16'(ep0c_pkg::DESCRIPTOR_LOAD_PORT_BYTES);

  // decoded command strobes
  logic wr_descriptor_load_port, wr_buf, rd_buf, wr_setup, rd_setup, wr_count, rd_count;
  logic wr_inten, rd_inten;
  assign wr_descriptor_load_port = CMD.wr && CMD.addr == ep0c_pkg::ADDR_DESCRIPTOR_LOAD_PORT_LOAD;
  assign wr_buf = CMD.wr && CMD.addr == ep0c_pkg::ADDR_EP0_BUF;
  assign rd_buf = CMD.rd && CMD.addr == ep0c_pkg::ADDR_EP0_BUF;
  assign wr_setup = CMD.wr && CMD.addr == ep0c_pkg::ADDR_SETUP;
  assign rd_setup = CMD.rd && CMD.addr == ep0c_pkg::ADDR_SETUP;
  assign wr_count = CMD.wr && CMD.addr == ep0c_pkg::ADDR_EP0_COUNT;
  assign rd_count = CMD.rd && CMD.addr == ep0c_pkg::ADDR_EP0_COUNT;
  assign wr_inten = CMD.wr && CMD.addr == ep0c_pkg::ADDR_INT_ENABLE;
  assign rd_inten = CMD.rd && CMD.addr == ep0c_pkg::ADDR_INT_ENABLE;

  logic [7:0] descriptor_load_port_ram [ep0c_pkg::DESCRIPTOR_LOAD_PORT_BYTES]; // descriptor storage
  logic [7:0] buf_mem [ep0c_pkg::BUF_BYTES]; // endpoint-zero buffer
  logic [7:0] setup_mem [ep0c_pkg::SETUP_BYTES]; // last setup packet
  logic [7:0] int_enable; // interrupt enable mask
  logic [5:0] mptr; // master buffer pointer
  logic [6:0] uptr; // usb OUT fill count
  logic [6:0] out_count; // bytes of last OUT stage
  logic [2:0] sidx; // setup read index
  logic in_busy; // IN stage owned by usb core
  logic setup_pend, buf_pend; // sticky interrupt causes
  logic [6:0] next_in_count; // clamped IN count
  ep0c_pkg::ep0c_descriptor_load_port_state_t descriptor_load_port_state;
  logic [15:0] descriptor_load_port_ptr; // next descriptor byte
  logic byte_we;
  logic [7:0] byte_val;

  // descriptor port carries one nibble per transfer
  ep0c_nibble_pack u_pack
  (
    .clk(SYS_CLK),
    .rst_n(ARST_N),
    .nib_we(wr_descriptor_load_port),
    .nib(CMD.wdata[3:0]),
    .byte_we(byte_we),
    .byte_out(byte_val)
  );

  // descriptor loader: length low, length high, then data
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      descriptor_load_port_state <= ep0c_pkg::DESCRIPTOR_LOAD_PORT_LEN_LO;
      DESCRIPTOR_LOAD_PORT_LEN <= 16'h0000;
      descriptor_load_port_ptr <= 16'h0000;
      DESCRIPTOR_LOAD_PORT_READY <= 1'b0;
    end
    else if (byte_we)
    begin
      unique case (descriptor_load_port_state)
        ep0c_pkg::DESCRIPTOR_LOAD_PORT_LEN_LO:
        begin
          DESCRIPTOR_LOAD_PORT_LEN[7:0] <= byte_val;
          DESCRIPTOR_LOAD_PORT_READY <= 1'b0;
          descriptor_load_port_state <= ep0c_pkg::DESCRIPTOR_LOAD_PORT_LEN_HI;
        end
        ep0c_pkg::DESCRIPTOR_LOAD_PORT_LEN_HI:
        begin
          DESCRIPTOR_LOAD_PORT_LEN[15:8] <= byte_val;
          descriptor_load_port_ptr <= 16'h0000;
          // an empty descriptor finishes at once
          if ({byte_val, DESCRIPTOR_LOAD_PORT_LEN[7:0]} == 16'h0000)
          begin
            DESCRIPTOR_LOAD_PORT_READY <= 1'b1;
            descriptor_load_port_state <= ep0c_pkg::DESCRIPTOR_LOAD_PORT_LEN_LO;
          end
          else
            descriptor_load_port_state <= ep0c_pkg::DESCRIPTOR_LOAD_PORT_DATA;
        end
        ep0c_pkg::DESCRIPTOR_LOAD_PORT_DATA:
        begin
          descriptor_load_port_ptr <= descriptor_load_port_ptr + 16'h0001;
          // relies on the master sending exactly the announced count
          if (descriptor_load_port_ptr + 16'h0001 == DESCRIPTOR_LOAD_PORT_LEN)
          begin
            DESCRIPTOR_LOAD_PORT_READY <= 1'b1;
            descriptor_load_port_state <= ep0c_pkg::DESCRIPTOR_LOAD_PORT_LEN_LO;
          end
        end
      endcase
    end
  end

  // descriptor storage; bytes past the end are dropped, not wrapped
  always_ff @(posedge SYS_CLK)
  begin
    if (byte_we && descriptor_load_port_state == ep0c_pkg::DESCRIPTOR_LOAD_PORT_DATA &&
        descriptor_load_port_ptr < DESCRIPTOR_LOAD_PORT_MAX)
      descriptor_load_port_ram[descriptor_load_port_ptr[8:0]] <= byte_val;
  end

  // registered read port for the usb core
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      USB_DESCRIPTOR_LOAD_PORT_RDATA <= 8'h00;
    else if (USB_DESCRIPTOR_LOAD_PORT_RADDR < DESCRIPTOR_LOAD_PORT_MAX[8:0])
      USB_DESCRIPTOR_LOAD_PORT_RDATA <= descriptor_load_port_ram[USB_DESCRIPTOR_LOAD_PORT_RADDR];
    else
      USB_DESCRIPTOR_LOAD_PORT_RDATA <= 8'h00;
  end

  // setup packet capture from the usb core
  always_ff @(posedge SYS_CLK)
  begin
    if (USB_SETUP_WE)
      setup_mem[USB_SETUP_IDX] <= USB_SETUP_DATA;
  end

  // buffer storage; usb OUT data wins over a colliding master write
  always_ff @(posedge SYS_CLK)
  begin
    if (USB_OUT_WE && uptr < BUF_MAX)
      buf_mem[uptr[5:0]] <= USB_OUT_DATA;
    else if (wr_buf && !in_busy)
      buf_mem[mptr] <= CMD.wdata;
  end

  // IN data read by the usb core
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      USB_IN_RDATA <= 8'h00;
    else
      USB_IN_RDATA <= buf_mem[USB_IN_RADDR];
  end

  // pointers and OUT byte count
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      mptr <= 6'h00;
      uptr <= 7'h00;
      out_count <= 7'h00;
      sidx <= 3'h0;
    end
    else
    begin
      // a new stage restarts the master at byte zero
      if (wr_count || USB_OUT_DONE || USB_IN_DONE || USB_SETUP_DONE)
        mptr <= 6'h00;
      else if ((wr_buf && !in_busy) || rd_buf)
        mptr <= mptr + 6'h01;
      if (USB_OUT_DONE || USB_SETUP_DONE)
        uptr <= 7'h00;
      else if (USB_OUT_WE && uptr < BUF_MAX)
        uptr <= uptr + 7'h01;
      if (USB_OUT_DONE)
        out_count <= uptr;
      if (USB_SETUP_DONE)
        sidx <= 3'h0;
      else if (rd_setup)
        sidx <= sidx + 3'h1;
    end
  end

  // oversize counts are clamped to the buffer size
  always_comb
  begin
    if (CMD.wdata > 8'(ep0c_pkg::BUF_BYTES))
      next_in_count = BUF_MAX;
    else
      next_in_count = CMD.wdata[6:0];
  end

  // IN stage launch; a count written while busy is ignored
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      in_busy <= 1'b0;
      USB_IN_GO <= 1'b0;
      USB_IN_COUNT <= 7'h00;
    end
    else
    begin
      USB_IN_GO <= 1'b0;
      if (wr_count && !in_busy)
      begin
        in_busy <= 1'b1;
        USB_IN_GO <= 1'b1;
        USB_IN_COUNT <= next_in_count;
      end
      else if (USB_IN_DONE)
        in_busy <= 1'b0;
    end
  end

  // stall: set by master write, lifted by the next setup packet
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      EP0_STALL <= 1'b0;
    else if (wr_setup)
      EP0_STALL <= 1'b1;
    else if (USB_SETUP_DONE)
      EP0_STALL <= 1'b0;
  end

  // interrupt mask and sticky causes; set beats clear
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      int_enable <= ep0c_pkg::INT_ENABLE_RESET;
      setup_pend <= 1'b0;
      buf_pend <= 1'b0;
    end
    else
    begin
      if (wr_inten)
        int_enable <= CMD.wdata;
      if (USB_SETUP_DONE)
        setup_pend <= 1'b1;
      else if (rd_setup)
        setup_pend <= 1'b0;
      if (USB_IN_DONE || USB_OUT_DONE)
        buf_pend <= 1'b1;
      else if (wr_count || rd_count)
        buf_pend <= 1'b0;
    end
  end

  // one active-low interrupt line
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      INT_N <= 1'b1;
    else
      INT_N <= !((setup_pend && int_enable[ep0c_pkg::INT_SETUP_BIT]) ||
                 (buf_pend && int_enable[ep0c_pkg::INT_BUF_BIT]));
  end

  // command read data, valid one cycle after the read
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      CMD_RDATA <= 8'h00;
      CMD_RVALID <= 1'b0;
    end
    else
    begin
      CMD_RVALID <= CMD.rd;
      if (rd_buf)
        CMD_RDATA <= buf_mem[mptr];
      else if (rd_setup)
        CMD_RDATA <= setup_mem[sidx];
      else if (rd_count)
        CMD_RDATA <= {1'b0, out_count};
      else if (rd_inten)
        CMD_RDATA <= int_enable;
      else
        CMD_RDATA <= 8'h00; // unmapped and write-only read zero
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  a_stall_on_write: assert property (wr_setup |=> EP0_STALL)
    else $error("stall missing after setup write");
  a_stall_lifted: assert property (
    USB_SETUP_DONE && !wr_setup |=> !EP0_STALL)
    else $error("stall not lifted by setup");
  a_setup_irq: assert property (
    USB_SETUP_DONE && int_enable[7] && !wr_inten |=> ##1 !INT_N)
    else $error("setup interrupt missing");
  a_buf_irq: assert property (
    USB_IN_DONE && int_enable[6] && !wr_inten |=> ##1 !INT_N)
    else $error("buffer interrupt missing");
  a_in_launch: assert property (
    wr_count && !in_busy |=> USB_IN_GO && USB_IN_COUNT <= BUF_MAX
    ##1 !USB_IN_GO)
    else $error("IN launch wrong");
  a_setup_read: assert property (
    rd_setup |=> CMD_RVALID && CMD_RDATA == setup_mem[$past(sidx)])
    else $error("setup byte mismatch");
  a_out_count: assert property (
    rd_count |=> CMD_RDATA == {1'b0, $past(out_count)})
    else $error("OUT count mismatch");
  a_buf_ptr: assert property (
    rd_buf && !wr_count && !USB_OUT_DONE && !USB_IN_DONE &&
    !USB_SETUP_DONE |=> mptr == $past(mptr) + 6'h01)
    else $error("buffer pointer stuck");
  a_descriptor_load_port_done: assert property (
    $rose(DESCRIPTOR_LOAD_PORT_READY) |-> descriptor_load_port_state == ep0c_pkg::DESCRIPTOR_LOAD_PORT_LEN_LO &&
    descriptor_load_port_ptr <= DESCRIPTOR_LOAD_PORT_LEN)
    else $error("descriptor end wrong");
endmodule

// file: sim/ep0c_usb_model.sv
`timescale 1ns/1ps
// usb side stand-in: feeds setup and OUT data, drains IN data
module ep0c_usb_model
(
  input wire logic clk,
  output logic setup_we,
  output logic [2:0] setup_idx,
  output logic [7:0] setup_data,
  output logic setup_done,
  output logic out_we,
  output logic [7:0] out_data,
  output logic out_done,
  output logic [5:0] in_raddr,
  input wire logic [7:0] in_rdata,
  output logic in_done,
  output logic [8:0] descriptor_load_port_raddr,
  input wire logic [7:0] descriptor_load_port_rdata
);
  logic [7:0] in_bytes [64]; // bytes seen in the last IN stage
  initial
  begin
    {setup_we, setup_idx, setup_data, setup_done} = '0;
    {out_we, out_data, out_done, in_raddr, in_done, descriptor_load_port_raddr} = '0;
  end
  // eight setup bytes back to back, then the done pulse
  task automatic send_setup(input logic [63:0] pkt);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      setup_we <= 1'b1;
      setup_idx <= 3'(i);
      setup_data <= pkt[8*i +: 8];
    end
    @(posedge clk);
    setup_we <= 1'b0;
    setup_data <= ~setup_data; // idle data never echoes the last byte
    setup_done <= 1'b1;
    @(posedge clk);
    setup_done <= 1'b0;
  endtask
  // OUT stage of n bytes counting up from first
  task automatic send_out(input int n, input logic [7:0] first);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      out_we <= 1'b1;
      out_data <= first + 8'(i);
    end
    @(posedge clk);
    out_we <= 1'b0;
    out_data <= ~out_data;
    out_done <= 1'b1;
    @(posedge clk);
    out_done <= 1'b0;
  endtask
  // IN stage: fetch n bytes one at a time, then free the buffer
  task automatic take_in(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      in_raddr <= 6'(i);
      @(posedge clk);
      #1 in_bytes[i] = in_rdata;
    end
    @(posedge clk);
    in_done <= 1'b1;
    @(posedge clk);
    in_done <= 1'b0;
  endtask
  // descriptor fetch as enumeration would do it
  task automatic read_descriptor_load_port(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    descriptor_load_port_raddr <= a;
    @(posedge clk);
    #1 d = descriptor_load_port_rdata;
  endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  ep0c_pkg::ep0c_cmd_t cmd = '0;
  logic [7:0] cmd_rdata, in_rdata, descriptor_load_port_rdata, setup_data, out_data, rd;
  logic cmd_rvalid, int_n, stall, setup_we, setup_done, out_we, out_done;
  logic in_go, in_done, descriptor_load_port_ready;
  logic [2:0] setup_idx;
  logic [6:0] in_count;
  logic [5:0] in_raddr;
  logic [8:0] descriptor_load_port_raddr;
  logic [15:0] descriptor_load_port_len;
  logic [63:0] pkt = 64'h1122334455667788;
  logic [7:0] dsc [5] = '{8'h03, 8'h00, 8'ha5, 8'h3c, 8'h0f};
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  ep0c_top ep0c_top_i (.SYS_CLK(sys_clk), .ARST_N(arst_n), .CMD(cmd),
    .CMD_RDATA(cmd_rdata), .CMD_RVALID(cmd_rvalid), .INT_N(int_n),
    .EP0_STALL(stall), .USB_SETUP_WE(setup_we), .USB_SETUP_IDX(setup_idx),
    .USB_SETUP_DATA(setup_data), .USB_SETUP_DONE(setup_done),
    .USB_OUT_WE(out_we), .USB_OUT_DATA(out_data), .USB_OUT_DONE(out_done),
    .USB_IN_GO(in_go), .USB_IN_COUNT(in_count), .USB_IN_RADDR(in_raddr),
    .USB_IN_RDATA(in_rdata), .USB_IN_DONE(in_done),
    .USB_DESCRIPTOR_LOAD_PORT_RADDR(descriptor_load_port_raddr), .USB_DESCRIPTOR_LOAD_PORT_RDATA(descriptor_load_port_rdata),
    .DESCRIPTOR_LOAD_PORT_LEN(descriptor_load_port_len), .DESCRIPTOR_LOAD_PORT_READY(descriptor_load_port_ready));
  ep0c_usb_model ep0c_usb_model_i (.clk(sys_clk), .setup_we(setup_we),
    .setup_idx(setup_idx), .setup_data(setup_data),
    .setup_done(setup_done), .out_we(out_we), .out_data(out_data),
    .out_done(out_done), .in_raddr(in_raddr), .in_rdata(in_rdata),
    .in_done(in_done), .descriptor_load_port_raddr(descriptor_load_port_raddr), .descriptor_load_port_rdata(descriptor_load_port_rdata));
  // verdict and end of run, shared with the hang guard
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one command write, request held for exactly one edge
  task automatic cmd_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cmd <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    cmd <= '0;
    #1;
  endtask
  // one command read; data is taken in the valid cycle
  task automatic cmd_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    cmd <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    cmd <= '0;
    #1;
    check("cmd_rvalid", 16'h0001, 16'(cmd_rvalid));
    d = cmd_rdata;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    cmd_rd(a, rd);
    check(what, 16'(exp), 16'(rd));
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    check("int_n", 16'h0001, 16'(int_n));
    check("stall", 16'h0000, 16'(stall));
    // length 3 low byte first, then three bytes, each as two nibbles
    foreach (dsc[i])
    begin
      cmd_wr(ep0c_pkg::ADDR_DESCRIPTOR_LOAD_PORT_LOAD, {4'h0, dsc[i][3:0]});
      cmd_wr(ep0c_pkg::ADDR_DESCRIPTOR_LOAD_PORT_LOAD, {4'h0, dsc[i][7:4]});
    end
    wait_cyc(1);
    check("descriptor_load_port_len", 16'h0003, descriptor_load_port_len);
    check("descriptor_load_port_ready", 16'h0001, 16'(descriptor_load_port_ready));
    for (int i = 0; i < 3; i++)
    begin
      ep0c_usb_model_i.read_descriptor_load_port(9'(i), rd);
      check("descriptor_load_port byte", 16'(dsc[i+2]), 16'(rd));
    end
    rd_chk("descriptor_load_port port read", ep0c_pkg::ADDR_DESCRIPTOR_LOAD_PORT_LOAD, 8'h00);
    // setup arrival raises the interrupt, reads clear it
    ep0c_usb_model_i.send_setup(pkt);
    wait_cyc(2);
    check("int_n setup", 16'h0000, 16'(int_n));
    for (int i = 0; i < 8; i++)
      rd_chk("setup byte", ep0c_pkg::ADDR_SETUP, pkt[8*i +: 8]);
    wait_cyc(1);
    check("int_n cleared", 16'h0001, 16'(int_n));
    cmd_wr(ep0c_pkg::ADDR_SETUP, 8'h00);
    check("stall", 16'h0001, 16'(stall));
    ep0c_usb_model_i.send_setup(~pkt);
    rd_chk("new setup", ep0c_pkg::ADDR_SETUP, ~pkt[7:0]);
    check("stall lifted", 16'h0000, 16'(stall));
    // masked setup source stays quiet
    cmd_wr(ep0c_pkg::ADDR_INT_ENABLE, 8'h00);
    ep0c_usb_model_i.send_setup(pkt);
    wait_cyc(2);
    check("int_n masked", 16'h0001, 16'(int_n));
    cmd_rd(ep0c_pkg::ADDR_SETUP, rd);
    cmd_wr(ep0c_pkg::ADDR_INT_ENABLE, ep0c_pkg::INT_ENABLE_RESET);
    // OUT stage of five bytes
    ep0c_usb_model_i.send_out(5, 8'h10);
    wait_cyc(2);
    check("int_n out", 16'h0000, 16'(int_n));
    rd_chk("out count", ep0c_pkg::ADDR_EP0_COUNT, 8'h05);
    for (int i = 0; i < 5; i++)
      rd_chk("buf read", ep0c_pkg::ADDR_EP0_BUF, 8'h10 + 8'(i));
    // echo the OUT data back IN, then refill after the buffer frees
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1)
      begin
        for (int n = 0; n < 10 && int_n !== 1'b0; n++)
          wait_cyc(1);
        check("int_n free", 16'h0000, 16'(int_n));
        cmd_rd(ep0c_pkg::ADDR_EP0_COUNT, rd);
        for (int i = 0; i < 4; i++)
          cmd_wr(ep0c_pkg::ADDR_EP0_BUF, 8'hc0 + 8'(i));
      end
      cmd_wr(ep0c_pkg::ADDR_EP0_COUNT, k ? 8'h04 : 8'h05);
      check("in_go", 16'h0001, 16'(in_go));
      check("in_count", k ? 16'h0004 : 16'h0005, 16'(in_count));
      ep0c_usb_model_i.take_in(k ? 4 : 5);
      for (int i = 0; i < (k ? 4 : 5); i++)
        check("in byte", 16'((k ? 8'hc0 : 8'h10) + 8'(i)),
              16'(ep0c_usb_model_i.in_bytes[i]));
    end
    rd_chk("unmapped", 8'h00, 8'h00);
    complete_run();
  end
endmodule
